// File: dtc_params.svh
// Register offsets, field positions, reset values and timing counts of the dual timer/counter.
// Included by the package user files; definitions only.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
// ===================================================
// Register word indexes; the APB byte address is four times the index
`define DTC_OFS_RUN_FLAG 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_CNT0_LO 8'h8A
`define DTC_OFS_CNT1_LO 8'h8B
`define DTC_OFS_CNT0_HI 8'h8C
`define DTC_OFS_CNT1_HI 8'h8D
`define DTC_OFS_AUX 8'h8E
`define DTC_OFS_CLKOUT 8'h8F
// ===================================================
// Field positions
`define DTC_CTL_FLAG1 7
`define DTC_CTL_RUN1 6
`define DTC_CTL_FLAG0 5
`define DTC_CTL_RUN0 4
`define DTC_MOD_GATE 3
`define DTC_MOD_SRC 2
`define DTC_AUX_FULL0 7
`define DTC_AUX_FULL1 6
`define DTC_CLKO_EN1 1
`define DTC_CLKO_EN0 0
// ===================================================
// Reset values
`define DTC_RST_BYTE 8'h00
// ===================================================
// Timing: slow prescale ratio in system clocks
`define DTC_PRESCALE_DIV 4'hC
`define DTC_PRESCALE_MAX 4'hB
`endif

// File: dtc_pkg.sv
// Types shared by the dual timer/counter files.
// Assumes nothing beyond a SystemVerilog compiler.
package dtc_pkg;
   // Operating mode per timer
   typedef enum logic [1:0] {
      DTC_MODE_13BIT,
      DTC_MODE_16BIT,
      DTC_MODE_RELOAD,
      DTC_MODE_SPLIT
   } dtc_mode_t;
endpackage : dtc_pkg

// File: dtc_prescaler.sv
// Shared divide-by-twelve tick source for slow timer rate.
// Assumes one system clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   // ===================================================
   // Free-running counter; tick once per twelve clocks
   logic [3:0] div_count; // Position within the twelve-clock period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 4'h0;
      end else if (div_count == `DTC_PRESCALE_MAX) begin
         div_count <= 4'h0;
      end else begin
         div_count <= div_count + 4'h1;
      end
   end
   // Combinational tick, last clock of each period
   assign tick = (div_count == `DTC_PRESCALE_MAX);
endmodule : dtc_prescaler

// File: dtc_edge_detect.sv
// Falling-edge detector for an external count pin.
// Input is taken as synchronous to pclk; two samples are compared.
`timescale 1ns/1ps
module dtc_edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic fall
);
   // ===================================================
   // Sample every rising edge; high then low is a falling edge
   logic prev_sample; // Previous sample of the pin
   logic cur_sample; // Latest sample of the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_sample <= 1'b0;
         cur_sample <= 1'b0;
      end else begin
         cur_sample <= pin;
         prev_sample <= cur_sample;
      end
   end
   // Registered pulse so the count moves the cycle after detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall <= 1'b0;
      end else begin
         fall <= prev_sample & ~cur_sample;
      end
   end
endmodule : dtc_edge_detect

// File: dtc_timer.sv
// Dual 8-bit-pair timer/counter with APB register access.
// Assumes pins synchronous to pclk and an APB master with setup and access phases.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic count_input_0,
   input wire logic count_input_1,
   input wire logic gate_pin_0,
   input wire logic gate_pin_1,
   output logic clkout0,
   output logic clkout1,
   output logic overflow_flag_0,
   output logic overflow_flag_1
);
   // ===================================================
   // Registers
   logic [7:0] timer_run_flag_control; // Flags and run bits in upper nibble
   logic [7:0] timer_mode_select; // Upper nibble timer 1, lower timer 0
   logic [7:0] auxiliary_rate_control; // Full-rate selects
   logic [7:0] wake_and_clock_out_control; // Clock-out enables
   logic [7:0] count_lo [2]; // Low count bytes
   logic [7:0] count_hi [2]; // High count bytes
   logic [1:0] clk_toggle; // Clock-out toggles
   logic prescale_tick; // Slow-rate tick
   logic [1:0] pin_fall; // Detected falling edges
   logic [1:0] inc_lo; // Low byte increments this cycle
   logic inc_hi_split; // Timer 0 high byte increments in split mode
   logic [1:0] ovf; // Overflow event per flag
   logic [1:0] lo_wrap; // Low byte (or 5-bit part) wraps
   logic [1:0] hi_wrap; // High byte wraps
   logic [1:0] full_rate; // Per-timer rate selects
   logic [1:0] run_bit; // Per-timer run bits
   logic [1:0] gate_pin; // Per-timer gate pins
   logic [1:0] fall_raw; // Edge detector outputs
   logic wr_en; // APB write strobe
   logic [7:0] wbyte; // Write data low byte
   logic [7:0] reg_idx; // Word index of the addressed register
   logic addr_ok; // Aligned and inside the index space
   dtc_pkg::dtc_mode_t mode [2]; // Per-timer modes
   assign full_rate[0] = auxiliary_rate_control[`DTC_AUX_FULL0];
   assign full_rate[1] = auxiliary_rate_control[`DTC_AUX_FULL1];
   assign run_bit[0] = timer_run_flag_control[`DTC_CTL_RUN0];
   assign run_bit[1] = timer_run_flag_control[`DTC_CTL_RUN1];
   assign gate_pin[0] = gate_pin_0;
   assign gate_pin[1] = gate_pin_1;
   // One byte register per word; upper address bits must be zero or the write is dropped
   assign reg_idx = paddr[9:2];
   assign addr_ok = (paddr[31:10] == 22'h0) & (paddr[1:0] == 2'b00);
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign wbyte = pwdata[7:0];
   // ===================================================
   // Shared prescaler and edge detectors
   dtc_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .tick(prescale_tick)
   );
   dtc_edge_detect u_edge0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(count_input_0),
      .fall(fall_raw[0])
   );
   dtc_edge_detect u_edge1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(count_input_1),
      .fall(fall_raw[1])
   );
   assign pin_fall = fall_raw;
   // ===================================================
   // Per-timer count enables and wrap detection
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         logic [3:0] nib; // This timer's mode nibble
         logic tick; // Selected count source
         logic enabled; // Run and gate condition
         assign nib = timer_mode_select[gi*4 +: 4];
         assign mode[gi] = dtc_pkg::dtc_mode_t'(nib[1:0]);
         // Source: pin edge, else full-rate clock or prescaled tick
         assign tick = nib[`DTC_MOD_SRC] ? pin_fall[gi] :
            (full_rate[gi] ? 1'b1 : prescale_tick);
         assign enabled = run_bit[gi] & (~nib[`DTC_MOD_GATE] | gate_pin[gi]);
         // Timer 1 in split mode holds its count
         if (gi == 1) begin : g_second
            assign inc_lo[gi] = tick & enabled & (mode[gi] != dtc_pkg::DTC_MODE_SPLIT);
         end else begin : g_first
            assign inc_lo[gi] = tick & enabled;
         end
         assign lo_wrap[gi] = (mode[gi] == dtc_pkg::DTC_MODE_13BIT) ? (count_lo[gi][4:0] == 5'h1F) :
            (count_lo[gi] == 8'hFF);
         assign hi_wrap[gi] = (count_hi[gi] == 8'hFF);
      end
   endgenerate
   // Timer 0 high byte in split mode runs from timer 1's run bit
   assign inc_hi_split = (mode[0] == dtc_pkg::DTC_MODE_SPLIT) & run_bit[1] &
      (full_rate[0] ? 1'b1 : prescale_tick);
   // Overflow events to flags
   always_comb begin
      ovf = 2'b00;
      case (mode[0])
         dtc_pkg::DTC_MODE_13BIT,
         dtc_pkg::DTC_MODE_16BIT: ovf[0] = inc_lo[0] & lo_wrap[0] & hi_wrap[0];
         default: ovf[0] = inc_lo[0] & lo_wrap[0];
      endcase
      case (mode[1])
         dtc_pkg::DTC_MODE_13BIT,
         dtc_pkg::DTC_MODE_16BIT: ovf[1] = inc_lo[1] & lo_wrap[1] & hi_wrap[1];
         dtc_pkg::DTC_MODE_RELOAD: ovf[1] = inc_lo[1] & lo_wrap[1];
         default: ovf[1] = 1'b0;
      endcase
      // Split timer 0 high byte owns timer 1's flag
      if (mode[0] == dtc_pkg::DTC_MODE_SPLIT) begin
         ovf[1] = inc_hi_split & hi_wrap[0];
      end
   end
   // ===================================================
   // Count registers; software write wins over counting
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cnt
         logic lo_sel; // Write address hits low byte
         logic hi_sel; // Write address hits high byte
         assign lo_sel = wr_en & (reg_idx == (gi == 0 ? `DTC_OFS_CNT0_LO : `DTC_OFS_CNT1_LO));
         assign hi_sel = wr_en & (reg_idx == (gi == 0 ? `DTC_OFS_CNT0_HI : `DTC_OFS_CNT1_HI));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               count_lo[gi] <= `DTC_RST_BYTE;
            end else if (lo_sel) begin
               count_lo[gi] <= wbyte;
            end else if (inc_lo[gi]) begin
               if (mode[gi] == dtc_pkg::DTC_MODE_RELOAD && lo_wrap[gi]) begin
                  count_lo[gi] <= count_hi[gi];
               end else if (mode[gi] == dtc_pkg::DTC_MODE_13BIT) begin
                  count_lo[gi] <= {count_lo[gi][7:5], count_lo[gi][4:0] + 5'h01};
               end else begin
                  count_lo[gi] <= count_lo[gi] + 8'h01;
               end
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               count_hi[gi] <= `DTC_RST_BYTE;
            end else if (hi_sel) begin
               count_hi[gi] <= wbyte;
            end else if (gi == 0 && inc_hi_split) begin
               count_hi[gi] <= count_hi[gi] + 8'h01;
            end else if (inc_lo[gi] && lo_wrap[gi] &&
               (mode[gi] == dtc_pkg::DTC_MODE_13BIT || mode[gi] == dtc_pkg::DTC_MODE_16BIT)) begin
               count_hi[gi] <= count_hi[gi] + 8'h01;
            end
         end
         // Clock-out toggles once per overflow, giving half the overflow rate
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               clk_toggle[gi] <= 1'b0;
            end else if (ovf[gi]) begin
               clk_toggle[gi] <= ~clk_toggle[gi];
            end
         end
      end
   endgenerate
   // ===================================================
   // Control registers; hardware flag set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_run_flag_control <= `DTC_RST_BYTE;
      end else begin
         if (wr_en && reg_idx == `DTC_OFS_RUN_FLAG) begin
            timer_run_flag_control <= wbyte;
         end
         if (ovf[0]) begin
            timer_run_flag_control[`DTC_CTL_FLAG0] <= 1'b1;
         end
         if (ovf[1]) begin
            timer_run_flag_control[`DTC_CTL_FLAG1] <= 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_select <= `DTC_RST_BYTE;
         auxiliary_rate_control <= `DTC_RST_BYTE;
         wake_and_clock_out_control <= `DTC_RST_BYTE;
      end else if (wr_en) begin
         if (reg_idx == `DTC_OFS_MODE) begin
            timer_mode_select <= wbyte;
         end else if (reg_idx == `DTC_OFS_AUX) begin
            auxiliary_rate_control <= wbyte;
         end else if (reg_idx == `DTC_OFS_CLKOUT) begin
            wake_and_clock_out_control <= wbyte;
         end
      end
   end
   // ===================================================
   // APB read mux; zero wait states
   logic [7:0] rd_byte; // Selected register
   logic rd_hit; // Address is mapped
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (!addr_ok) begin
         rd_hit = 1'b0;
      end else if (reg_idx == `DTC_OFS_RUN_FLAG) begin
         rd_byte = timer_run_flag_control;
      end else if (reg_idx == `DTC_OFS_MODE) begin
         rd_byte = timer_mode_select;
      end else if (reg_idx == `DTC_OFS_CNT0_LO) begin
         rd_byte = count_lo[0];
      end else if (reg_idx == `DTC_OFS_CNT1_LO) begin
         rd_byte = count_lo[1];
      end else if (reg_idx == `DTC_OFS_CNT0_HI) begin
         rd_byte = count_hi[0];
      end else if (reg_idx == `DTC_OFS_CNT1_HI) begin
         rd_byte = count_hi[1];
      end else if (reg_idx == `DTC_OFS_AUX) begin
         rd_byte = auxiliary_rate_control;
      end else if (reg_idx == `DTC_OFS_CLKOUT) begin
         rd_byte = wake_and_clock_out_control;
      end else begin
         rd_hit = 1'b0;
      end
   end
   // Read data registered in the setup cycle, valid during access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rd_byte};
      end
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~rd_hit;
   // ===================================================
   // Pin outputs
   assign clkout0 = wake_and_clock_out_control[`DTC_CLKO_EN0] & clk_toggle[0];
   assign clkout1 = wake_and_clock_out_control[`DTC_CLKO_EN1] & clk_toggle[1];
   assign overflow_flag_0 = timer_run_flag_control[`DTC_CTL_FLAG0];
   assign overflow_flag_1 = timer_run_flag_control[`DTC_CTL_FLAG1];
   // ===================================================
   // Checks
   property p_flag0_set;
      @(posedge pclk) disable iff (!presetn) ovf[0] |=> overflow_flag_0;
   endproperty
   a_flag0_set: assert property (p_flag0_set) else $error("flag0 not set after overflow");
   property p_full_rate;
      @(posedge pclk) disable iff (!presetn)
         (mode[0] == dtc_pkg::DTC_MODE_16BIT && !timer_mode_select[2] && full_rate[0] && run_bit[0] &&
         !timer_mode_select[3] && !wr_en && !lo_wrap[0]) |=> (count_lo[0] == $past(count_lo[0]) + 8'h01);
   endproperty
   a_full_rate: assert property (p_full_rate) else $error("full-rate count did not advance");
   property p_edge_count;
      @(posedge pclk) disable iff (!presetn)
         (pin_fall[0] && timer_mode_select[2] && run_bit[0] && !timer_mode_select[3] &&
         (mode[0] == dtc_pkg::DTC_MODE_16BIT || mode[0] == dtc_pkg::DTC_MODE_RELOAD) &&
         !wr_en && !lo_wrap[0]) |=> (count_lo[0] == $past(count_lo[0]) + 8'h01);
   endproperty
   a_edge_count: assert property (p_edge_count) else $error("edge not counted");
   property p_gate;
      @(posedge pclk) disable iff (!presetn) (timer_mode_select[3] && !gate_pin_0) |-> !inc_lo[0];
   endproperty
   a_gate: assert property (p_gate) else $error("counted with gate low");
   property p_reload;
      @(posedge pclk) disable iff (!presetn)
         (mode[0] == dtc_pkg::DTC_MODE_RELOAD && inc_lo[0] && lo_wrap[0] && !wr_en) |=>
         (count_lo[0] == $past(count_hi[0]) && count_hi[0] == $past(count_hi[0]));
   endproperty
   a_reload: assert property (p_reload) else $error("reload wrong");
   property p_13bit;
      @(posedge pclk) disable iff (!presetn)
         (mode[0] == dtc_pkg::DTC_MODE_13BIT && inc_lo[0] && !wr_en) |=> count_lo[0][7:5] == $past(count_lo[0][7:5]);
   endproperty
   a_13bit: assert property (p_13bit) else $error("13-bit mode touched upper low bits");
   property p_t1_hold;
      @(posedge pclk) disable iff (!presetn)
         (mode[1] == dtc_pkg::DTC_MODE_SPLIT && !wr_en) |=>
         (count_lo[1] == $past(count_lo[1]) && count_hi[1] == $past(count_hi[1]));
   endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("timer 1 counted in mode 3");
   property p_clkout;
      @(posedge pclk) disable iff (!presetn) ovf[0] |=> clk_toggle[0] != $past(clk_toggle[0]);
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock out did not toggle");
endmodule : dtc_timer

// File: dtc_pin_model.sv
// Model of the external count pins that drive the dual timer/counter.
// Assumes the bench sets a half period per pin in system clocks; zero parks the pin high.
`timescale 1ns/1ps
module dtc_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] half0,
   input wire logic [7:0] half1,
   output logic count_input_0,
   output logic count_input_1
);
   // ==========================================
   // Pin state
   logic [7:0] cnt [2]; // Cycles spent in the current level
   logic [1:0] pin; // Driven levels
   assign count_input_0 = pin[0];
   assign count_input_1 = pin[1];
   // Square wave; a short half period would let the sampler miss a level
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 2; i++) begin
         if (!presetn) begin
            cnt[i] <= 8'h00;
            pin[i] <= 1'b1;
         end else if ((i == 0 ? half0 : half1) == 8'h00) begin
            // Parked high between bursts
            cnt[i] <= 8'h00;
            pin[i] <= 1'b1;
         end else if (cnt[i] >= (i == 0 ? half0 : half1) - 8'h01) begin
            cnt[i] <= 8'h00;
            pin[i] <= ~pin[i];
         end else begin
            cnt[i] <= cnt[i] + 8'h01;
         end
      end
   end
endmodule : dtc_pin_model

// File: dual_timer_counter_test.sv
// Self-checking bench for the dual timer/counter: APB master plus pin model.
// Assumes zero-wait APB slave and clock outputs that toggle on each overflow.
`timescale 1ns/1ps
module dual_timer_counter_test;
   // ==========================================
   // Signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic count_input_0, count_input_1, gate_pin_0, gate_pin_1;
   logic clkout0, clkout1, overflow_flag_0, overflow_flag_1;
   logic [7:0] half0, half1, d; // Pin half periods, random data
   int mismatches, samples_checked, seed, n;
   dtc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_input_0(count_input_0), .count_input_1(count_input_1), .gate_pin_0(gate_pin_0),
      .gate_pin_1(gate_pin_1), .clkout0(clkout0), .clkout1(clkout1),
      .overflow_flag_0(overflow_flag_0), .overflow_flag_1(overflow_flag_1));
   dtc_pin_model u_pins (.pclk(pclk), .presetn(presetn), .half0(half0), .half1(half1),
      .count_input_0(count_input_0), .count_input_1(count_input_1));
   // 25 MHz system clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ==========================================
   // Helpers
   task tally_and_finish;
      $display("Mismatches %0d, comparisons %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : chk
   // One APB transfer; an idle edge follows so no signal is assigned twice per step
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, a, 2'b00};
      pwdata <= {24'h000000, dat};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         mismatches++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Cycles between two successive toggles of a clock output
   task gap(input int which, output int cyc);
      int k, t;
      logic prev;
      prev = which ? clkout1 : clkout0;
      k = 0;
      cyc = 0;
      for (t = 0; t < 20000 && k < 2; t++) begin
         @(posedge pclk);
         cyc++;
         if ((which ? clkout1 : clkout0) !== prev) begin
            k++;
            prev = which ? clkout1 : clkout0;
            if (k == 1) cyc = 0;
         end
      end
      if (k < 2) begin
         mismatches++;
         tally_and_finish();
      end
   endtask : gap
   // Toggle spacing: counts per overflow times clocks per count
   function int exp_gap(input int span, input int per_tick);
      return span * per_tick;
   endfunction : exp_gap
   // ==========================================
   // Main sequence
   initial begin
      seed = 32'h43026F0D;
      mismatches = 0;
      samples_checked = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, gate_pin_0, gate_pin_1} = 5'h00;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      half0 = 8'h00;
      half1 = 8'h00;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, then an unmapped address is refused
      for (int a = 8'h88; a <= 8'h8F; a++) begin
         apb(1'b0, a[7:0], 8'h00);
         chk("reset value", 32'h00000000, rd);
      end
      apb(1'b1, 8'h90, 8'hA5);
      chk("unmapped write error", 32'h1, {31'h0, err});
      apb(1'b0, 8'h90, 8'h00);
      chk("unmapped read data", 32'h0, rd);
      // Random write and read-back with both timers stopped
      for (int a = 8'h89; a <= 8'h8F; a++) begin
         d = $random(seed);
         apb(1'b1, a[7:0], d);
         apb(1'b0, a[7:0], 8'h00);
         chk("register readback", {24'h0, d}, rd);
         chk("mapped error", 32'h0, {31'h0, err});
      end
      // Reload mode: timer 0 full rate, timer 1 slow rate, clock outputs on
      apb(1'b1, 8'h8E, 8'h80);
      apb(1'b1, 8'h89, 8'h22);
      apb(1'b1, 8'h8A, 8'hF0);
      apb(1'b1, 8'h8C, 8'hF0);
      apb(1'b1, 8'h8B, 8'hF8);
      apb(1'b1, 8'h8D, 8'hF8);
      apb(1'b1, 8'h8F, 8'h03);
      apb(1'b1, 8'h88, 8'h50);
      gap(0, n);
      chk("t0 reload gap", exp_gap(16, 1), n);
      gap(1, n);
      chk("t1 slow gap", exp_gap(8, 12), n);
      chk("t1 flag", 32'h1, {31'h0, overflow_flag_1});
      // Timer 0 counts pin edges while timer 1 keeps timing
      apb(1'b1, 8'h88, 8'h00);
      apb(1'b1, 8'h8E, 8'h40);
      apb(1'b1, 8'h89, 8'h26);
      half0 <= 8'h0C;
      apb(1'b1, 8'h88, 8'h50);
      gap(0, n);
      chk("t0 event gap", exp_gap(16, 24), n);
      gap(1, n);
      chk("t1 beside counter", exp_gap(8, 1), n);
      half0 <= 8'h00;
      // Thirteen-bit mode wraps every 8192 counts
      apb(1'b1, 8'h88, 8'h00);
      apb(1'b1, 8'h8E, 8'h80);
      apb(1'b1, 8'h89, 8'h00);
      apb(1'b1, 8'h88, 8'h10);
      gap(0, n);
      chk("mode0 gap", exp_gap(8192, 1), n);
      // Sixteen-bit mode: run keeps the count, rollover sets the flag
      apb(1'b1, 8'h88, 8'h00);
      apb(1'b1, 8'h89, 8'h01);
      apb(1'b1, 8'h8A, 8'hF0);
      apb(1'b1, 8'h8C, 8'hFF);
      apb(1'b1, 8'h88, 8'h10);
      apb(1'b0, 8'h8C, 8'h00);
      chk("high byte kept", 32'hFF, rd);
      for (int i = 0; i < 100 && overflow_flag_0 !== 1'b1; i++) @(posedge pclk);
      if (overflow_flag_0 !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
      apb(1'b0, 8'h88, 8'h00);
      chk("run and flag", 32'h30, rd & 32'h30);
      apb(1'b1, 8'h88, 8'h00);
      chk("flag cleared", 32'h0, {31'h0, overflow_flag_0});
      // Gate pins stop both timers until raised
      apb(1'b1, 8'h8E, 8'hC0);
      apb(1'b1, 8'h89, 8'h99);
      apb(1'b1, 8'h8A, 8'h00);
      apb(1'b1, 8'h8B, 8'h00);
      apb(1'b1, 8'h88, 8'h50);
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h8A, 8'h00);
      chk("t0 gated", 32'h0, rd);
      apb(1'b0, 8'h8B, 8'h00);
      chk("t1 gated", 32'h0, rd);
      gate_pin_0 <= 1'b1;
      gate_pin_1 <= 1'b1;
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h8A, 8'h00);
      chk("t0 gate open", 32'h1, {31'h0, rd !== 32'h0});
      apb(1'b0, 8'h8B, 8'h00);
      chk("t1 gate open", 32'h1, {31'h0, rd !== 32'h0});
      // Split mode: timer 1 holds, timer 0 high byte runs on the second run bit
      apb(1'b1, 8'h88, 8'h00);
      apb(1'b1, 8'h89, 8'h33);
      apb(1'b1, 8'h8B, 8'h55);
      apb(1'b1, 8'h8C, 8'h00);
      apb(1'b1, 8'h88, 8'h40);
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h8B, 8'h00);
      chk("t1 held in mode3", 32'h55, rd);
      apb(1'b0, 8'h8C, 8'h00);
      chk("t0 high byte runs", 32'h1, {31'h0, rd !== 32'h0});
      tally_and_finish();
   end
endmodule : dual_timer_counter_test
